// >>> hdl/pnvm_port.sv
// programming port logic with its page-latch FIFO
`timescale 1ns/1ns

//------------------------------------------------------------------
// small FIFO between the page latch strobe and the page buffer
//------------------------------------------------------------------
module pnvm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clockEn,
	input wire logic wValid,
	output logic wReady,
	input wire logic [WIDTH-1:0] wData,
	output logic rValid,
	input wire logic rReady,
	output logic [WIDTH-1:0] rData
);
	import pnvm_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [AW-1:0] wPtr;
		logic [AW-1:0] rPtr;
		logic [AW:0] count;
	} pnvm_fifo_t;
	pnvm_fifo_t s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic doPush, doPop;

	assign wReady = (s_q.count != (AW+1)'(DEPTH));
	assign rValid = (s_q.count != '0);
	assign rData = mem[s_q.rPtr];
	assign doPush = wValid && wReady;
	assign doPop = rValid && rReady;

	always_comb begin
		s_d = s_q;
		if (doPush) begin
			s_d.wPtr = (s_q.wPtr == AW'(DEPTH - 1)) ? '0 : s_q.wPtr + 1'b1;
		end
		if (doPop) begin
			s_d.rPtr = (s_q.rPtr == AW'(DEPTH - 1)) ? '0 : s_q.rPtr + 1'b1;
		end
		s_d.count = s_q.count + (AW+1)'(doPush) - (AW+1)'(doPop);
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_q <= '0;
		end else if (clockEn) begin
			s_q <= s_d;
		end
	end

	always_ff @(posedge clock) begin
		if (clockEn && doPush) begin
			mem[s_q.wPtr] <= wData;
		end
	end
endmodule : pnvm_fifo

//------------------------------------------------------------------
// programming port: entry check, loads, page writes, erase, reads
//------------------------------------------------------------------
module pnvm_port #(
	parameter int FLASH_AW = 13,
	parameter int EE_AW = 9,
	parameter int WRITE_CYCLES = 1000,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clockEn,
	input wire logic progVoltage,
	input wire logic crystalClockIn,
	input wire logic actionSelHi,
	input wire logic actionSelLo,
	input wire logic byteSelect1,
	input wire logic byteSelect2,
	input wire logic pageLatchStrobe,
	input wire logic wrN,
	input wire logic oeN,
	input wire logic [pnvm_pkg::BYTE_W-1:0] dataIn,
	output logic [pnvm_pkg::BYTE_W-1:0] dataOut,
	output logic dataOeN,
	output logic readyBusy,
	output logic progMode,
	output logic [pnvm_pkg::BYTE_W-1:0] fuseLow,
	output logic [pnvm_pkg::BYTE_W-1:0] fuseHigh,
	output logic [pnvm_pkg::BYTE_W-1:0] fuseExt,
	output logic [pnvm_pkg::BYTE_W-1:0] lockBits
);
	import pnvm_pkg::*;
	localparam int FLASH_WORDS = 1 << FLASH_AW;
	localparam int EE_BYTES = 1 << EE_AW;
	localparam int ENT_W = PAGE_IDX_W + 16;

	typedef struct packed {
		pnvm_state_t state;
		pnvm_op_t op;
		logic [7:0] cmd;
		logic [7:0] addrLo;
		logic [7:0] addrHi;
		logic [7:0] dataLo;
		logic [7:0] dataHi;
		logic [7:0] fuseLo;
		logic [7:0] fuseHi;
		logic [7:0] fuseExt;
		logic [7:0] lock;
		logic [15:0] idx;
		logic [31:0] timer;
		logic [1:0] entryCnt;
		logic [3:0] entryPins;
		logic xtalPrev;
		logic wrPrev;
		logic pglPrev;
		logic latchPend;
		logic [ENT_W-1:0] latchEnt;
		logic [FLASH_PAGE_WORDS-1:0] validMask;
		logic [7:0] dataOut;
		logic dataOeN;
		logic readyBusy;
		logic progMode;
	} pnvm_port_t;

	pnvm_port_t s_q, s_d;
	logic [15:0] flashMem [FLASH_WORDS];
	logic [7:0] eeMem [EE_BYTES];
	logic [15:0] pageBuf [FLASH_PAGE_WORDS];
	logic fifoWReady, fifoRValid, fifoRReady;
	logic [ENT_W-1:0] fifoRData;
	logic flashWe, eeWe, walkDone, preserveEe;
	logic [FLASH_AW-1:0] flashWa;
	logic [EE_AW-1:0] eeWa;
	logic [15:0] flashWd, addr;
	logic [7:0] eeWd;
	logic [3:0] entryNow;

	// the strobe's pending entry waits here while the FIFO is full
	pnvm_fifo #(.WIDTH(ENT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.nrst(nrst),
		.clockEn(clockEn),
		.wValid(s_q.latchPend),
		.wReady(fifoWReady),
		.wData(s_q.latchEnt),
		.rValid(fifoRValid),
		.rReady(fifoRReady),
		.rData(fifoRData)
	);

	assign addr = {s_q.addrHi, s_q.addrLo};
	assign entryNow = {pageLatchStrobe, actionSelHi, actionSelLo, wrN};
	assign preserveEe = !s_q.fuseHi[PRESERVE_BIT];

	always_comb begin
		s_d = s_q;
		flashWe = 1'b0;
		eeWe = 1'b0;
		flashWa = '0;
		eeWa = '0;
		flashWd = '0;
		eeWd = '0;
		walkDone = 1'b0;
		fifoRReady = (s_q.state != S_BUSY);
		s_d.xtalPrev = crystalClockIn;
		s_d.wrPrev = wrN;
		s_d.pglPrev = pageLatchStrobe;
		if (s_q.latchPend && fifoWReady) begin
			s_d.latchPend = 1'b0;
		end
		case (s_q.state)
			S_OFF: begin
				if (progVoltage) begin
					s_d.entryCnt = '0;
					s_d.entryPins = entryNow;
					s_d.state = (entryNow == 4'h0) ? S_ARM : S_REFUSED;
				end
			end
			S_ARM: begin
				if (entryNow != s_q.entryPins) begin
					s_d.state = S_REFUSED;
				end else if (s_q.entryCnt == 2'(ENTRY_CYC - 1)) begin
					s_d.state = S_PROG;
				end else begin
					s_d.entryCnt = s_q.entryCnt + 2'h1;
				end
			end
			S_PROG: begin
				if (crystalClockIn && !s_q.xtalPrev) begin
					case ({actionSelHi, actionSelLo})
						ACT_CMD: begin
							s_d.cmd = dataIn;
							if (dataIn == CMD_NOOP) begin
								s_d.validMask = '0;
							end
						end
						ACT_ADDR: begin
							if (byteSelect1) begin
								s_d.addrHi = dataIn;
							end else begin
								s_d.addrLo = dataIn;
							end
						end
						ACT_DATA: begin
							if (byteSelect1) begin
								s_d.dataHi = dataIn;
							end else begin
								s_d.dataLo = dataIn;
							end
						end
						default: begin
						end
					endcase
				end
				if (pageLatchStrobe && !s_q.pglPrev && !s_q.latchPend) begin
					s_d.latchPend = 1'b1;
					if (s_q.cmd == CMD_WR_EE) begin
						s_d.latchEnt = {PAGE_IDX_W'(s_q.addrLo[EE_IDX_W-1:0]), 8'hFF, s_q.dataLo};
					end else begin
						s_d.latchEnt = {s_q.addrLo[PAGE_IDX_W-1:0], s_q.dataHi, s_q.dataLo};
					end
				end
				// a strobe arriving before the buffer has settled is ignored
				if (s_q.wrPrev && !wrN && !fifoRValid && !s_q.latchPend) begin
					s_d.idx = '0;
					s_d.timer = '0;
					case (s_q.cmd)
						CMD_ERASE: begin
							s_d.op = OP_ERASE;
							s_d.state = S_BUSY;
						end
						CMD_WR_FLASH: begin
							s_d.op = OP_FLASH;
							s_d.state = S_BUSY;
						end
						CMD_WR_EE: begin
							if (!byteSelect1) begin
								s_d.op = OP_EE;
								s_d.state = S_BUSY;
							end
						end
						CMD_WR_FUSE: begin
							s_d.op = OP_FUSE;
							s_d.state = S_BUSY;
							if (byteSelect2) begin
								s_d.fuseExt = s_q.dataLo;
							end else if (byteSelect1) begin
								s_d.fuseHi = s_q.dataLo;
							end else begin
								s_d.fuseLo = s_q.dataLo;
							end
						end
						default: begin
						end
					endcase
				end
			end
			S_BUSY: begin
				case (s_q.op)
					OP_FLASH: begin
						walkDone = (s_q.idx >= 16'(FLASH_PAGE_WORDS));
						// upper low-byte bits pick the page, not the word
						flashWa = {addr[FLASH_AW-1:PAGE_IDX_W], s_q.idx[PAGE_IDX_W-1:0]};
						flashWd = flashMem[flashWa] & pageBuf[s_q.idx[PAGE_IDX_W-1:0]];
						flashWe = !walkDone && s_q.validMask[s_q.idx[PAGE_IDX_W-1:0]];
					end
					OP_EE: begin
						walkDone = (s_q.idx >= 16'(EE_PAGE_BYTES));
						eeWa = {addr[EE_AW-1:EE_IDX_W], s_q.idx[EE_IDX_W-1:0]};
						eeWd = pageBuf[s_q.idx[PAGE_IDX_W-1:0]][7:0];
						eeWe = !walkDone && s_q.validMask[s_q.idx[PAGE_IDX_W-1:0]];
					end
					OP_ERASE: begin
						walkDone = (s_q.idx >= 16'(FLASH_WORDS + EE_BYTES));
						flashWa = s_q.idx[FLASH_AW-1:0];
						flashWd = 16'hFFFF;
						flashWe = (s_q.idx < 16'(FLASH_WORDS));
						eeWa = s_q.idx[EE_AW-1:0];
						eeWd = 8'hFF;
						eeWe = !flashWe && !walkDone && !preserveEe;
					end
					default: begin
						walkDone = 1'b1;
					end
				endcase
				if (!walkDone) begin
					s_d.idx = s_q.idx + 16'h1;
				end else if (s_q.timer == 32'(WRITE_CYCLES - 1)) begin
					s_d.state = S_PROG;
					if (s_q.op == OP_ERASE) begin
						s_d.lock = LOCK_RST;
					end else if (s_q.op != OP_FUSE) begin
						s_d.validMask = '0;
					end
				end else begin
					s_d.timer = s_q.timer + 32'h1;
				end
			end
			S_REFUSED: begin
			end
			default: begin
				s_d.state = S_OFF;
			end
		endcase
		// after the no-op clear, so a word landing in the same cycle is not lost
		if (fifoRValid && fifoRReady) begin
			s_d.validMask[fifoRData[ENT_W-1:16]] = 1'b1;
		end
		if (!progVoltage) begin
			s_d.state = S_OFF;
		end
		s_d.readyBusy = (s_d.state != S_BUSY);
		s_d.progMode = (s_d.state == S_PROG) || (s_d.state == S_BUSY);
		s_d.dataOeN = 1'b1;
		s_d.dataOut = 8'hFF;
		if (!oeN && s_q.state == S_PROG) begin
			if (s_q.cmd == CMD_RD_FLASH) begin
				s_d.dataOeN = 1'b0;
				s_d.dataOut = byteSelect1 ? flashMem[addr[FLASH_AW-1:0]][15:8]
					: flashMem[addr[FLASH_AW-1:0]][7:0];
			end else if (s_q.cmd == CMD_RD_EE && !byteSelect1) begin
				s_d.dataOeN = 1'b0;
				s_d.dataOut = eeMem[addr[EE_AW-1:0]];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.state <= S_OFF;
			s_q.fuseLo <= FUSE_LO_RST;
			s_q.fuseHi <= FUSE_HI_RST;
			s_q.fuseExt <= FUSE_EXT_RST;
			s_q.lock <= LOCK_RST;
			s_q.dataOut <= 8'hFF;
			s_q.dataOeN <= 1'b1;
			s_q.readyBusy <= 1'b1;
			s_q.wrPrev <= 1'b1;
		end else if (clockEn) begin
			s_q <= s_d;
		end
	end

	// arrays have no reset; contents are whatever the last session left
	always_ff @(posedge clock) begin
		if (clockEn) begin
			if (flashWe) begin
				flashMem[flashWa] <= flashWd;
			end
			if (eeWe) begin
				eeMem[eeWa] <= eeWd;
			end
			if (fifoRValid && fifoRReady) begin
				pageBuf[fifoRData[ENT_W-1:16]] <= fifoRData[15:0];
			end
		end
	end

	assign dataOut = s_q.dataOut;
	assign dataOeN = s_q.dataOeN;
	assign readyBusy = s_q.readyBusy;
	assign progMode = s_q.progMode;
	assign fuseLow = s_q.fuseLo;
	assign fuseHigh = s_q.fuseHi;
	assign fuseExt = s_q.fuseExt;
	assign lockBits = s_q.lock;
endmodule : pnvm_port

// >>> pkg/pnvm_pkg.sv
// constants and types shared by the parallel nonvolatile programming port
//------------------------------------------------------------------
// Overview of operation
// - entry pin change within 100ns refuses entry
// - command and address persist across operations
// - address high byte kept within 256 window
// - erase clears flash, eeprom, then lock bits; fuses kept
// - preserve fuse programmed keeps eeprom on erase
// - action 1,0 clock edge loads command
// - action 00 loads address low or high
// - action 0,1 loads data low or high
// - page latch pulse moves data to buffer
// - upper address low bits select page
// - write strobe programs flash page, busy low
// - decode erase, write flash, write eeprom
// - command zero is noop, ends page writes
// - read flash drives low or high byte
// - read eeprom drives byte with select low
// - eeprom page programmed by strobe, busy low
// - fuse write: zero programs, one erases
// - byte selects pick low, high, extended fuses
// - ready/busy low while busy, high when ready
// - data bus driven only while output enable low
//------------------------------------------------------------------
package pnvm_pkg;
	localparam int BYTE_W = 8;
	localparam int CLK_NS = 50;
	localparam int ENTRY_NS = 100;
	localparam int ENTRY_CYC = (ENTRY_NS + CLK_NS - 1) / CLK_NS;
	localparam int FLASH_PAGE_WORDS = 64;
	localparam int EE_PAGE_BYTES = 4;
	localparam int PAGE_IDX_W = 6;
	localparam int EE_IDX_W = 2;
	localparam int PRESERVE_BIT = 6;
	localparam logic [7:0] CMD_NOOP = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE = 8'h11;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE = 8'h03;
	localparam logic [7:0] FUSE_LO_RST = 8'hFF;
	localparam logic [7:0] FUSE_HI_RST = 8'hFF;
	localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
	localparam logic [7:0] LOCK_RST = 8'hFF;
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	typedef enum logic [2:0] {
		S_OFF = 3'h0,
		S_ARM = 3'h1,
		S_PROG = 3'h3,
		S_BUSY = 3'h2,
		S_REFUSED = 3'h6
	} pnvm_state_t;
	typedef enum logic [1:0] {
		OP_FLASH = 2'h0,
		OP_EE = 2'h1,
		OP_ERASE = 2'h2,
		OP_FUSE = 2'h3
	} pnvm_op_t;
endpackage : pnvm_pkg

// >>> sim/pnvm_port_sva.sv
// assertions on the programming port pins
`timescale 1ns/1ns
//----
// checker
//----
module pnvm_port_sva (
	input wire logic clock,
	input wire logic nrst,
	input wire logic progVoltage,
	input wire logic pageLatchStrobe,
	input wire logic actionSelHi,
	input wire logic actionSelLo,
	input wire logic wrN,
	input wire logic oeN,
	input wire logic [7:0] dataOut,
	input wire logic dataOeN,
	input wire logic readyBusy,
	input wire logic progMode,
	input wire logic [7:0] fuseLow,
	input wire logic [7:0] fuseHigh,
	input wire logic [7:0] fuseExt
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	wire pinsZero = ({pageLatchStrobe, actionSelHi, actionSelLo, wrN} == 4'h0);
	sequence entryClean;
		$rose(progVoltage) && pinsZero ##1 (progVoltage && pinsZero) [*2];
	endsequence
	sequence entryDirty;
		$rose(progVoltage) && !pinsZero ##1 progVoltage [*4];
	endsequence
	a_entry_ok: assert property (entryClean |-> ##[1:3] progMode)
		else $error("entry with quiet pins did not reach mode");
	a_entry_refuse: assert property (entryDirty |-> !progMode)
		else $error("entry with active pins was not refused");
	a_mode_drop: assert property (!progVoltage |=> !progMode)
		else $error("mode kept without programming voltage");
	a_mode_ready: assert property ($rose(progMode) |-> readyBusy)
		else $error("mode entered while busy");
	a_busy_in_mode: assert property (!readyBusy |-> progMode)
		else $error("busy outside programming mode");
	a_busy_cause: assert property ($fell(readyBusy) |-> !$past(wrN) || !$past(wrN, 2))
		else $error("busy without write strobe");
	a_busy_hold: assert property ($fell(readyBusy) |-> !readyBusy [*3])
		else $error("busy pulse too short");
	a_drive_oe: assert property (!dataOeN |-> !$past(oeN) && progMode)
		else $error("bus driven without output enable");
	a_oe_release: assert property ($past(oeN) |-> dataOeN && dataOut == 8'hFF)
		else $error("bus not released after output enable");
	a_fuse_cause: assert property ($changed({fuseLow, fuseHigh, fuseExt}) && $past(nrst)
		|-> !$past(wrN) || !$past(wrN, 2))
		else $error("fuse changed without write strobe");
endmodule : pnvm_port_sva
bind pnvm_port pnvm_port_sva pnvm_port_sva_i (.clock, .nrst, .progVoltage, .pageLatchStrobe,
	.actionSelHi, .actionSelLo, .wrN, .oeN, .dataOut, .dataOeN, .readyBusy, .progMode,
	.fuseLow, .fuseHigh, .fuseExt);

// >>> sim/pnvm_prog_model.sv
// programmer side of the shared data bus
`timescale 1ns/1ns
//----
// bus model
//----
module pnvm_prog_model (
	input wire logic clock,
	input wire logic oeN,
	input wire logic dataOeN,
	input wire logic [7:0] dataOut,
	input wire logic [7:0] progData,
	output logic [7:0] bus
);
	logic [7:0] last = 8'h00;
	// a floating bus shows the inverse of its last value, never a friendly copy
	always_comb begin
		if (!dataOeN) begin
			bus = dataOut;
		end else if (oeN) begin
			bus = progData;
		end else begin
			bus = ~last;
		end
	end
	always @(posedge clock) begin
		last <= bus;
	end
endmodule : pnvm_prog_model

// >>> sim/tb_top.sv
// self-checking bench for the programming port
`timescale 1ns/1ns
//----
// bench
//----
module tb_top;
	import pnvm_pkg::*;
	logic clock = 1'h0, nrst = 1'h0, clockEn = 1'h1, progVoltage = 1'h0, crystalClockIn = 1'h0;
	logic actionSelHi = 1'h1, actionSelLo = 1'h1, byteSelect1 = 1'h0, byteSelect2 = 1'h0;
	logic pageLatchStrobe = 1'h0, wrN = 1'h1, oeN = 1'h1, dataOeN, readyBusy, progMode;
	logic [7:0] dataIn, dataOut, fuseLow, fuseHigh, fuseExt, lockBits, progData = 8'h00;
	int errors = 0, samples_checked = 0;
	always #25 clock = ~clock;
	pnvm_port #(.FLASH_AW(9), .WRITE_CYCLES(4)) pnvm_port_i (.clock, .nrst, .clockEn,
		.progVoltage, .crystalClockIn, .actionSelHi, .actionSelLo, .byteSelect1, .byteSelect2,
		.pageLatchStrobe, .wrN, .oeN, .dataIn, .dataOut, .dataOeN, .readyBusy, .progMode,
		.fuseLow, .fuseHigh, .fuseExt, .lockBits);
	pnvm_prog_model pnvm_prog_model_i (.clock, .oeN, .dataOeN, .dataOut, .progData,
		.bus(dataIn));
	task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp8
	task automatic cyc(int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	task automatic load(logic [1:0] act, logic b1, logic [7:0] v);
		@(posedge clock);
		{actionSelHi, actionSelLo} <= act;
		byteSelect1 <= b1;
		progData <= v;
		@(posedge clock);
		crystalClockIn <= 1'h1;
		@(posedge clock);
		crystalClockIn <= 1'h0;
		{actionSelHi, actionSelLo} <= 2'h3;
	endtask : load
	task automatic latch;
		@(posedge clock);
		pageLatchStrobe <= 1'h1;
		@(posedge clock);
		pageLatchStrobe <= 1'h0;
		cyc(3);
	endtask : latch
	// a strobe that must be ignored still leaves the port ready
	task automatic pulse(logic b1, logic b2, logic busy);
		@(posedge clock);
		byteSelect1 <= b1;
		byteSelect2 <= b2;
		@(posedge clock);
		wrN <= 1'h0;
		@(posedge clock);
		wrN <= 1'h1;
		cyc(2);
		@(negedge clock);
		cmp8("busyStart", {7'h00, !busy}, {7'h00, readyBusy});
		for (int i = 0; i < 3000 && readyBusy !== 1'h1; i++) @(posedge clock);
		@(negedge clock);
		cmp8("busyEnd", 8'h01, {7'h00, readyBusy});
	endtask : pulse
	task automatic rd(logic b1, logic [7:0] exp);
		@(posedge clock);
		oeN <= 1'h0;
		byteSelect1 <= b1;
		cyc(2);
		@(negedge clock);
		cmp8("driveOn", 8'h00, {7'h00, dataOeN});
		cmp8("readData", exp, dataIn);
		@(posedge clock);
		oeN <= 1'h1;
		cyc(1);
		@(negedge clock);
		cmp8("driveOff", 8'h01, {7'h00, dataOeN});
	endtask : rd
	// late is what the entry pins show one cycle after the voltage rises
	task automatic enter(logic [3:0] pins, logic [3:0] late, logic expMode);
		@(posedge clock);
		{pageLatchStrobe, actionSelHi, actionSelLo, wrN} <= pins;
		progVoltage <= 1'h0;
		repeat (6) begin
			@(posedge clock);
			crystalClockIn <= !crystalClockIn;
		end
		progVoltage <= 1'h1;
		@(posedge clock);
		{pageLatchStrobe, actionSelHi, actionSelLo, wrN} <= late;
		cyc(5);
		@(negedge clock);
		cmp8("progMode", {7'h00, expMode}, {7'h00, progMode});
		@(posedge clock);
		{pageLatchStrobe, actionSelHi, actionSelLo, wrN} <= 4'h7;
	endtask : enter
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		cyc(20000);
		errors++;
		$display("watchdog expired");
		end_sim();
	end
	initial begin
		cyc(12);
		nrst <= 1'h1;
		@(negedge clock);
		cmp8("readyRst", 8'h01, {7'h00, readyBusy});
		cmp8("lockRst", LOCK_RST, lockBits);
		enter(4'h4, 4'h4, 1'h0);
		enter(4'h0, 4'h1, 1'h0);
		enter(4'h0, 4'h0, 1'h1);
		cyc(1000);
		$display("test entry done");
		load(ACT_CMD, 1'h0, CMD_ERASE);
		pulse(1'h0, 1'h0, 1'h1);
		load(ACT_CMD, 1'h0, CMD_WR_FLASH);
		load(ACT_ADDR, 1'h0, 8'h41);
		load(ACT_DATA, 1'h0, 8'h3C);
		load(ACT_DATA, 1'h1, 8'hA5);
		latch();
		load(ACT_ADDR, 1'h1, 8'h01);
		pulse(1'h0, 1'h0, 1'h1);
		load(ACT_CMD, 1'h0, CMD_NOOP);
		pulse(1'h0, 1'h0, 1'h0);
		load(ACT_CMD, 1'h0, CMD_RD_FLASH);
		rd(1'h0, 8'h3C);
		rd(1'h1, 8'hA5);
		load(ACT_ADDR, 1'h0, 8'h40);
		rd(1'h0, 8'hFF);
		$display("test flash done");
		load(ACT_CMD, 1'h0, CMD_WR_EE);
		load(ACT_ADDR, 1'h0, 8'h02);
		load(ACT_DATA, 1'h0, 8'h5E);
		latch();
		pulse(1'h1, 1'h0, 1'h0);
		pulse(1'h0, 1'h0, 1'h1);
		load(ACT_CMD, 1'h0, CMD_RD_EE);
		rd(1'h0, 8'h5E);
		// a load given while the clock enable is low must leave the read command in place
		@(posedge clock);
		clockEn <= 1'h0;
		load(ACT_CMD, 1'h0, CMD_WR_FUSE);
		@(posedge clock);
		clockEn <= 1'h1;
		pulse(1'h0, 1'h0, 1'h0);
		$display("test eeprom done");
		load(ACT_CMD, 1'h0, CMD_WR_FUSE);
		load(ACT_DATA, 1'h0, 8'hBF);
		pulse(1'h1, 1'h0, 1'h1);
		load(ACT_DATA, 1'h0, 8'hF0);
		pulse(1'h0, 1'h1, 1'h1);
		load(ACT_DATA, 1'h0, 8'h7E);
		pulse(1'h0, 1'h0, 1'h1);
		cmp8("fuseHigh", 8'hBF, fuseHigh);
		cmp8("fuseExt", 8'hF0, fuseExt);
		cmp8("fuseLow", 8'h7E, fuseLow);
		$display("test fuse done");
		load(ACT_CMD, 1'h0, CMD_ERASE);
		pulse(1'h0, 1'h0, 1'h1);
		cmp8("fuseKept", 8'hBF, fuseHigh);
		cmp8("lockErase", LOCK_RST, lockBits);
		load(ACT_CMD, 1'h0, CMD_RD_EE);
		rd(1'h0, 8'h5E);
		load(ACT_CMD, 1'h0, CMD_RD_FLASH);
		load(ACT_ADDR, 1'h0, 8'h41);
		rd(1'h1, 8'hFF);
		@(posedge clock);
		progVoltage <= 1'h0;
		cyc(2);
		@(negedge clock);
		cmp8("modeOff", 8'h00, {7'h00, progMode});
		$display("test erase done");
		end_sim();
	end
endmodule : tb_top
